/* File: design/adc_calibration_sequencer.sv */
/*
  Converter end: calibration sequencer, coefficients and corrected results.
  Assumes a host on cal_link_if and raw converter samples on the user side.
*/
// Notes on behaviour
// (RL1) mode 010 starts zero-scale system step
// (RL2) mode 011 starts full-scale system step
// (RL3) ready low when each system step ends
// (RL4) host holds zero-scale voltage, zero first
// (RL5) host holds full-scale voltage during step
// (RL6) zero step alone keeps earlier gain
// (RL7) bipolar range calibrates midscale to full
// (RL8) mode 100 system offset, gain from reference
// (RL9) offset calibration is one step
// (RL10) mode 101 interleaves background calibration
// (RL11) background results at one sixth rate
// (RL12) background stays until mode changes
// (RL13) background refreshes coefficients automatically
// (RL14) first background result invalid, discard
// (RL15) durations nine, four, nine, six periods
// (RL16) reset loads control register default
// (RL17) host calibrates after power-up
// (RL18) host waits for stable external reference
// (RL19) mode 001 self-calibration, shorted then reference
// (RL20) host ignores ready one modulator cycle
// (RL21) subtract offset, then multiply by gain
`timescale 1ns/10ps
`default_nettype none
`include "cal_seq_consts.svh"
module adc_calibration_sequencer #(
  parameter int OUT_PERIOD = `OUT_PERIOD
) (
  input  wire logic               clk,
  input  wire logic               rst,
  cal_link_if.dev                 link,
  input  wire logic [23:0]        analog_input_pair,
  input  wire logic [23:0]        shorted_sample,
  input  wire logic [23:0]        reference_sample,
  input  wire logic               bipolar,
  output logic [2:0]              mode_out,
  output logic [23:0]             offset_coef,
  output logic [23:0]             gain_coef,
  output logic                    busy
);
  import cal_seq_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  cal_state_e  state_q, state_d;
  mode_t       mode_q;
  logic [15:0] tick_q;
  logic [3:0]  per_q, per_d;
  logic [3:0]  bg_q;
  logic        bg_first_q;
  logic        rdy_n_q;
  logic [23:0] res_q, off_q, gain_q;
  logic [23:0] zero_pt_q;

  wire         out_tick  = (tick_q == 16'(OUT_PERIOD - 1));
  wire         is_cal    = link.mode_wr && (link.mode != `MODE_IDLE) && (link.mode <= `MODE_BACKGROUND);
  // midscale as zero in bipolar range, see (RL7)
  wire  [23:0] zero_ref  = bipolar ? (analog_input_pair ^ 24'h800000) : analog_input_pair;
  wire  [23:0] zero_sh   = bipolar ? (shorted_sample ^ 24'h800000) : shorted_sample;
  wire  [23:0] span_ref  = reference_sample - zero_pt_q;
  wire  [23:0] span_ain  = analog_input_pair - zero_pt_q;
  // gain is span in q2.22, taken directly to avoid divide hardware; zero span gives GAIN_RESET
  wire  [23:0] gain_ref  = (span_ref == 24'h000000) ? `GAIN_RESET : span_ref;
  wire  [23:0] gain_ain  = (span_ain == 24'h000000) ? `GAIN_RESET : span_ain;
  wire  [23:0] sub_val   = analog_input_pair - off_q;
  wire  [47:0] prod      = sub_val * gain_q;
  wire  [23:0] corrected = prod[45:22]; // see (RL21)
  wire  [3:0]  dur       = (link.mode == `MODE_SELF)      ? `PER_SELF :
                           (link.mode == `MODE_SYS_OFF)   ? `PER_SYS_OFF :
                           (link.mode == `MODE_BACKGROUND)? `PER_BACKGROUND : `PER_SYS_STEP; // see (RL15)

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    per_d   = per_q;
    unique case (state_q)
      S_IDLE, S_RUN: ;
      S_ZERO, S_FULL, S_SETTLE: begin
        if (out_tick && per_q != 4'h0) begin
          per_d = per_q - 4'h1;
        end
        if (out_tick && per_q == 4'h1) begin
          state_d = (mode_q == `MODE_BACKGROUND) ? S_RUN : S_IDLE;
        end
      end
    endcase
    if (is_cal) begin
      per_d   = dur;
      state_d = (link.mode == `MODE_SYS_FULL) ? S_FULL : S_ZERO; // see (RL1) (RL2) (RL8) (RL19)
    end else if (link.mode_wr) begin
      state_d = S_IDLE; // leaving background on any other code, see (RL12)
    end
  end

  // control register and timing, see (RL16)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      mode_q  <= `MODE_RESET;
      per_q   <= 4'h0;
      tick_q  <= 16'h0000;
    end else begin
      state_q <= state_d;
      per_q   <= per_d;
      if (link.mode_wr) begin
        mode_q <= link.mode;
      end
      // calibration command restarts the filter timing
      tick_q <= (is_cal || out_tick) ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  // ****************************************************************
  // coefficients
  // ****************************************************************
  // sample zero, or full scale in a full step, at the first period of each step, reference at the second; gain is untouched by zero step
  function automatic logic [3:0] dur_hold(input logic [2:0] m);
    dur_hold = (m == `MODE_SELF || m == `MODE_SYS_OFF) ? `PER_SELF :
               (m == `MODE_BACKGROUND) ? `PER_BACKGROUND : `PER_SYS_STEP;
  endfunction
  wire first_per = out_tick && (per_q == dur_hold(mode_q));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_q     <= `OFFSET_RESET;
      gain_q    <= `GAIN_RESET;
      zero_pt_q <= `OFFSET_RESET;
      bg_q      <= 4'h0;
    end else if (first_per && state_q == S_ZERO) begin
      unique case (mode_q)
        `MODE_SYS_ZERO: begin
          off_q     <= zero_ref; // see (RL1) (RL6)
          zero_pt_q <= analog_input_pair;
        end
        `MODE_SYS_OFF: begin
          off_q     <= zero_ref; // see (RL8)
          zero_pt_q <= analog_input_pair;
        end
        default: begin
          off_q     <= zero_sh; // see (RL19) (RL10)
          zero_pt_q <= shorted_sample;
        end
      endcase
    end else if (out_tick && per_q == dur_hold(mode_q) - 4'h1 && state_q == S_ZERO &&
                 mode_q != `MODE_SYS_ZERO) begin
      gain_q <= gain_ref; // reference conversion follows the zero one
    end else if (first_per && state_q == S_FULL) begin
      gain_q <= gain_ain; // see (RL2)
    end else if (state_q == S_RUN && out_tick) begin
      // interleave shorted, reference and four normal slots, see (RL10) (RL13)
      bg_q <= (bg_q == `BG_RATE_DIV - 4'h1) ? 4'h0 : bg_q + 4'h1;
      if (bg_q == 4'h0) begin
        off_q     <= zero_sh;
        zero_pt_q <= shorted_sample;
      end
      if (bg_q == 4'h1) begin
        gain_q <= gain_ref;
      end
    end else if (state_q != S_RUN) begin
      bg_q <= 4'h0; // each background entry starts at the shorted slot, see (RL11)
    end
  end

  // ****************************************************************
  // ready and result
  // ****************************************************************
  wire step_done = out_tick && per_q == 4'h1 && state_q != S_IDLE && state_q != S_RUN;
  wire bg_out    = state_q == S_RUN && out_tick && bg_q == `BG_RATE_DIV - 4'h1; // see (RL11)
  wire nrm_out   = state_q == S_IDLE && out_tick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_n_q    <= 1'b1;
      res_q      <= 24'h000000;
      bg_first_q <= 1'b0;
    end else begin
      if (is_cal) begin
        rdy_n_q    <= 1'b1; // ready rises on a command, see (RL20)
        bg_first_q <= (link.mode == `MODE_BACKGROUND);
      end else if (step_done || bg_out || nrm_out) begin
        rdy_n_q <= 1'b0; // see (RL3) (RL9) (RL15)
        // first background word is passed raw for the host to discard, see (RL14)
        res_q      <= bg_first_q ? analog_input_pair : corrected;
        bg_first_q <= 1'b0;
      end else if (link.result_ack) begin
        rdy_n_q <= 1'b1;
      end
    end
  end

  assign link.result_ready_n = rdy_n_q;
  assign link.result         = res_q;

  // user-side mirrors, registered one cycle behind state; busy is taken from next state, so it keeps step with state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_out    <= `MODE_RESET;
      offset_coef <= `OFFSET_RESET;
      gain_coef   <= `GAIN_RESET;
      busy        <= 1'b0;
    end else begin
      mode_out    <= mode_q;
      offset_coef <= off_q;
      gain_coef   <= gain_q;
      busy        <= (state_d != S_IDLE) && (state_d != S_RUN);
    end
  end
endmodule
`default_nettype wire

/* File: design/cal_seq_consts.svh */
/*
  Constants shared by both ends of the calibration link.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef CAL_SEQ_CONSTS_SVH
`define CAL_SEQ_CONSTS_SVH
// ****************************************************************
// mode codes and timing
// ****************************************************************
`define MODE_IDLE       3'h0
`define MODE_SELF       3'h1
`define MODE_SYS_ZERO   3'h2
`define MODE_SYS_FULL   3'h3
`define MODE_SYS_OFF    3'h4
`define MODE_BACKGROUND 3'h5
`define MODE_RESET      3'h0
`define PER_SELF        4'h9
`define PER_SYS_STEP    4'h4
`define PER_SYS_OFF     4'h9
`define PER_BACKGROUND  4'h6
`define BG_RATE_DIV     4'h6
`define OUT_PERIOD      16
`define MOD_CYCLE       2
`define OFFSET_RESET    24'h000000
`define GAIN_RESET      24'h400000
`endif

/* File: design/cal_seq_pkg.sv */
/*
  Types for the calibration sequencer.
  Assumes cal_seq_consts.svh is compiled alongside.
*/
package cal_seq_pkg;
  typedef logic [2:0] mode_t;
  typedef enum logic [2:0] {
    S_IDLE, S_ZERO, S_FULL, S_SETTLE, S_RUN
  } cal_state_e;
endpackage

/* File: design/cal_link_if.sv */
/*
  Interface between host and converter sequencer.
  Assumes one shared clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface cal_link_if;
  logic [2:0]  mode;
  logic        mode_wr;
  logic        result_ready_n;
  logic [23:0] result;
  logic        result_ack;
  modport dev (input mode, mode_wr, result_ack, output result_ready_n, result);
  modport host (output mode, mode_wr, result_ack, input result_ready_n, result);
endinterface
`default_nettype wire

/* File: design/cal_host.sv */
/*
  Host end: issues calibration commands and collects results.
  Assumes the converter end on cal_link_if and one shared clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cal_seq_consts.svh"
module cal_host (
  input  wire logic        clk,
  input  wire logic        rst,
  cal_link_if.host         link,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_mode,
  input  wire logic        ref_stable,
  output logic             cmd_ready,
  output logic             step_done,
  output logic             data_valid,
  output logic [23:0]      data
);
  import cal_seq_pkg::*;

  // ****************************************************************
  // command issue
  // ****************************************************************
  logic [2:0]  mode_q;
  logic        wr_q, ack_q, wait_q, have_zero_q, discard_q;
  logic [1:0]  blank_q;

  // full step only after zero step, and never before reference settles, see (RL4) (RL18)
  // blanking also spaces writes, so no two commands land back to back
  wire ok_cmd = cmd_valid && ref_stable && !wait_q && blank_q == 2'h0 &&
                (cmd_mode != `MODE_SYS_FULL || have_zero_q);
  // ready seen only after blanking, see (RL20)
  wire rdy    = !link.result_ready_n && blank_q == 2'h0 && !ack_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= `MODE_RESET;
      wr_q <= 1'b0;
      ack_q <= 1'b0;
      wait_q <= 1'b0;
      have_zero_q <= 1'b0;
      discard_q <= 1'b0;
      blank_q <= 2'h0;
      cmd_ready <= 1'b0;
      step_done <= 1'b0;
      data_valid <= 1'b0;
      data <= 24'h000000;
    end else begin
      wr_q <= ok_cmd;
      ack_q <= rdy;
      step_done <= 1'b0;
      data_valid <= 1'b0;
      cmd_ready <= ref_stable && !wait_q && !ok_cmd && blank_q <= 2'h1;
      if (blank_q != 2'h0) begin
        blank_q <= blank_q - 2'h1;
      end
      if (ok_cmd) begin
        mode_q  <= cmd_mode;
        // voltages stay applied by the user until step_done, see (RL5)
        wait_q  <= cmd_mode != `MODE_BACKGROUND && cmd_mode != `MODE_IDLE;
        blank_q <= 2'(`MOD_CYCLE);
        discard_q <= cmd_mode == `MODE_BACKGROUND;
        if (cmd_mode == `MODE_SYS_ZERO) begin
          have_zero_q <= 1'b1;
        end
      end else if (rdy) begin
        if (wait_q) begin
          wait_q <= 1'b0;
          step_done <= 1'b1;
        end else if (discard_q) begin
          discard_q <= 1'b0; // see (RL14)
        end else begin
          data_valid <= 1'b1;
          data <= link.result;
        end
      end
    end
  end

  assign link.mode       = mode_q;
  assign link.mode_wr    = wr_q;
  assign link.result_ack = ack_q;
endmodule
`default_nettype wire

/* File: tb/cal_link_sva.sv */
/*
  Checker on the host/converter calibration link.
  Assumes the interface signals are wired in by name, one clock, async high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cal_seq_consts.svh"
module cal_link_sva #(
  parameter int OUT_PERIOD = 16
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [2:0]  mode,
  input wire logic        mode_wr,
  input wire logic        result_ready_n,
  input wire logic [23:0] result,
  input wire logic        result_ack
);
  // ****************************************
  // timing windows and helpers
  // ****************************************
  // windows allow one period of slack: the step may end on a period boundary
  localparam int LO_SYS = 4 * OUT_PERIOD - 2;
  localparam int HI_SYS = 5 * OUT_PERIOD + 2;
  localparam int LO_NINE = 9 * OUT_PERIOD - 2;
  localparam int HI_NINE = 10 * OUT_PERIOD + 2;
  localparam int LO_BG = 6 * OUT_PERIOD - 2;
  localparam int HI_BG = 7 * OUT_PERIOD + 2;
  localparam int BG_GAP = 6 * OUT_PERIOD - 1;
  logic [7:0] since_wr_q;
  logic [7:0] since_fall_q;
  logic [2:0] last_mode_q;
  logic       pend_q;
  logic       zero_done_q;
  logic       rdy_prev_q;
  wire        fall = rdy_prev_q & ~result_ready_n;
  // counters saturate so a long idle spell never wraps into a window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_wr_q   <= 8'h00;
      since_fall_q <= 8'h00;
      last_mode_q  <= 3'h0;
      pend_q       <= 1'b0;
      zero_done_q  <= 1'b0;
      rdy_prev_q   <= 1'b1;
    end else begin
      rdy_prev_q   <= result_ready_n;
      since_wr_q   <= mode_wr ? 8'h00 : since_wr_q + {7'h0, since_wr_q != 8'hff};
      since_fall_q <= fall ? 8'h00 : since_fall_q + {7'h0, since_fall_q != 8'hff};
      last_mode_q  <= mode_wr ? mode : last_mode_q;
      pend_q       <= mode_wr ? (mode inside {[3'h1:3'h5]}) : (pend_q & ~fall);
      zero_done_q  <= zero_done_q | (fall & pend_q & (last_mode_q == `MODE_SYS_ZERO));
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // only calibration codes raise ready; an idle write leaves it alone
  a_wr_lifts_ready: assert property (mode_wr && mode != `MODE_IDLE && mode <= `MODE_BACKGROUND
    |-> ##[1:2] result_ready_n) else $error("ready not raised after a calibration write");
  a_sys_step_time: assert property (fall && pend_q && last_mode_q inside {`MODE_SYS_ZERO, `MODE_SYS_FULL}
    |-> since_wr_q >= LO_SYS && since_wr_q <= HI_SYS) else $error("system step length wrong");
  a_long_cal_time: assert property (fall && pend_q && last_mode_q inside {`MODE_SELF, `MODE_SYS_OFF}
    |-> since_wr_q >= LO_NINE && since_wr_q <= HI_NINE) else $error("one-step calibration length wrong");
  a_bg_first_word: assert property (fall && pend_q && last_mode_q == `MODE_BACKGROUND
    |-> since_wr_q >= LO_BG && since_wr_q <= HI_BG) else $error("first background word mistimed");
  a_bg_rate: assert property (fall && !pend_q && last_mode_q == `MODE_BACKGROUND
    |-> since_fall_q == BG_GAP) else $error("background word spacing wrong");
  a_full_needs_zero: assert property (mode_wr && mode == `MODE_SYS_FULL |-> zero_done_q)
    else $error("full-scale step written before zero-scale");
  a_ready_stands: assert property (!result_ready_n && !result_ack && !mode_wr |=> !result_ready_n)
    else $error("ready released without ack");
  a_ack_on_ready: assert property (result_ack |-> !result_ready_n)
    else $error("ack while ready high");
  a_wr_spacing: assert property (mode_wr |=> !mode_wr [*2])
    else $error("mode writes too close");
  c_zero_step: cover property (fall && pend_q && last_mode_q == `MODE_SYS_ZERO);
  c_self_step: cover property (fall && pend_q && last_mode_q == `MODE_SELF);
  c_bg_word: cover property (fall && !pend_q && last_mode_q == `MODE_BACKGROUND);
endmodule
`default_nettype wire

/* File: tb/adc_calibration_sequencer_tb.sv */
/*
  Bench: host end and converter end joined by cal_link_if.
  Assumes design files and cal_seq_consts.svh on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cal_seq_consts.svh"
module adc_calibration_sequencer_tb;
  // ****************************************
  // set-up
  // ****************************************
  localparam int P = 4; // short output period keeps the run brief
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        ref_stable = 1'b0;
  logic [2:0]  cmd_mode = 3'h0;
  logic [23:0] analog = 24'h0;
  logic [23:0] shorted = 24'h0;
  logic        bipolar = 1'b0;
  logic        cmd_ready, step_done, data_valid, busy;
  logic [23:0] data, offset_coef, gain_coef;
  logic [2:0]  mode_out;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          wr_cnt = 0;
  cal_link_if link();
  adc_calibration_sequencer #(.OUT_PERIOD(P)) i_adc_calibration_sequencer (.clk(clk), .rst(rst), .link(link),
    .analog_input_pair(analog), .shorted_sample(shorted), .reference_sample(24'h7fffff), .bipolar(bipolar),
    .mode_out(mode_out), .offset_coef(offset_coef), .gain_coef(gain_coef), .busy(busy));
  cal_host i_cal_host (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
    .ref_stable(ref_stable), .cmd_ready(cmd_ready), .step_done(step_done), .data_valid(data_valid), .data(data));
  cal_link_sva #(.OUT_PERIOD(P)) i_cal_link_sva (.clk(clk), .rst(rst), .mode(link.mode), .mode_wr(link.mode_wr),
    .result_ready_n(link.result_ready_n), .result(link.result), .result_ack(link.result_ack));
  always #4 clk = ~clk;
  // count accepted writes on the wire; refusals must leave this alone
  always @(posedge clk) if (link.mode_wr === 1'b1) wr_cnt++;
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // hold the command until cmd_ready is seen at an edge, or give up after 20
  task issue(input logic [2:0] m);
    int i;
    cmd_mode = m;
    cmd_valid = 1'b1;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 20);
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    // one edge passes, so a following call never re-raises valid in this step
    @(posedge clk);
    #1;
  endtask
  // one-cycle pulses are caught at the falling edge
  task wait_ev(input bit dv);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while ((dv ? data_valid : step_done) !== 1'b1 && i < 2000);
    if (i >= 2000) check(24'h0, 24'h1);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task results;
    $display("errors=%0d tests=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    check(offset_coef, `OFFSET_RESET);
    check(gain_coef, `GAIN_RESET);
    check({21'h0, mode_out}, {21'h0, `MODE_RESET});
    issue(`MODE_SELF);
    check(wr_cnt[23:0], 24'h0);
    ref_stable = 1'b1;
    issue(`MODE_SYS_FULL);
    check(wr_cnt[23:0], 24'h0);
    analog = 24'h012345;
    issue(`MODE_SYS_ZERO); // first calibration after power-up
    check({23'h0, busy}, 24'h1);
    wait_ev(1'b0);
    check({23'h0, busy}, 24'h0);
    check(offset_coef, 24'h012345);
    check(wr_cnt[23:0], 24'h1);
    analog = 24'h6abcde;
    issue(`MODE_SYS_FULL);
    wait_ev(1'b0);
    check(offset_coef, 24'h012345);
    check(gain_coef, 24'h699999); // span above the zero point
    analog = 24'h000777;
    issue(`MODE_SYS_ZERO);
    wait_ev(1'b0);
    check(offset_coef, 24'h000777);
    check(gain_coef, 24'h699999);
    // input at the offset reads zero only if offset goes before gain
    wait_ev(1'b1);
    wait_ev(1'b1);
    check(data, 24'h000000);
    analog = 24'h001234;
    issue(`MODE_SYS_OFF);
    wait_ev(1'b0);
    check(offset_coef, 24'h001234);
    check(gain_coef, 24'h7fedcb);
    shorted = 24'h000055;
    issue(`MODE_SELF);
    wait_ev(1'b0);
    check(offset_coef, 24'h000055);
    check(gain_coef, 24'h7fffaa);
    issue(`MODE_BACKGROUND);
    wait_ev(1'b1);
    shorted = 24'h0000aa; // drift the shorted node; background must follow it unaided
    wait_ev(1'b1);
    wait_ev(1'b1);
    check(offset_coef, 24'h0000aa);
    check(gain_coef, 24'h7fff55);
    check({21'h0, mode_out}, {21'h0, `MODE_BACKGROUND});
    issue(`MODE_IDLE);
    wait_ev(1'b1);
    check({21'h0, mode_out}, {21'h0, `MODE_IDLE});
    bipolar = 1'b1;
    analog = 24'h800100;
    issue(`MODE_SYS_ZERO);
    wait_ev(1'b0);
    check(offset_coef, 24'h000100); // midscale taken as zero
    results;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    check(24'h0, 24'h1);
    results;
  end
endmodule
`default_nettype wire
